// ===== dv/scc_strobe_src.sv
// Behavioural strobe source: free-running sample clock, alignment strobe and expected tick.
`timescale 1ns/1ps
module scc_strobe_src (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              go,
  input  wire logic              lvl,
  input  wire logic              tick_en,
  input  wire logic signed [3:0] tick_ofs,
  output logic                   sample_clk,
  output logic                   strobe,
  output logic                   tick,
  output logic                   busy
);
  logic       half_r;
  logic [3:0] fall_r;

  // The sample clock toggles every second core edge, so each sample clock period spans four core cycles.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_r     <= 1'b0;
      sample_clk <= 1'b0;
    end else begin
      half_r <= ~half_r;
      if (half_r) begin
        sample_clk <= ~sample_clk;
      end
    end
  end

  // Strobe and tick change only with a falling sample clock, half a period clear of the rise.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy   <= 1'b0;
      fall_r <= 4'h0;
      strobe <= 1'b0;
      tick   <= 1'b0;
    end else if (go) begin
      busy   <= 1'b1;
      fall_r <= 4'h0;
    end else if (busy && half_r && sample_clk) begin
      fall_r <= fall_r + 4'h1;
      if (fall_r == 4'h4) begin
        strobe <= lvl;
      end
      tick <= tick_en && (int'(fall_r) == 4 + int'(tick_ofs));
      if (fall_r == 4'hA) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the strobe capture control block.
`timescale 1ns/1ps
module testbench;
  import scc_pkg::*;
  logic                  CORE_CLK = 1'b0;
  logic                  RST_B    = 1'b0;
  logic                  PSEL     = 1'b0;
  logic                  PENABLE  = 1'b0;
  logic                  PWRITE   = 1'b0;
  logic [SCC_ADDR_W-1:0] PADDR    = '0;
  logic [SCC_DATA_W-1:0] PWDATA   = '0;
  logic [SCC_DATA_W-1:0] PRDATA;
  logic                  PREADY;
  logic                  PSLVERR;
  logic                  SAMPLE_CLK;
  logic                  STROBE_IN;
  logic                  EXPECT_TICK;
  logic [SCC_ERR_W-1:0]  SETUP_ERR = '0;
  logic [SCC_ERR_W-1:0]  HOLD_ERR  = '0;
  logic                  STROBE_ACT;
  logic                  go = 1'b0;
  logic                  lvl = 1'b0;
  logic                  tick_en = 1'b0;
  logic signed [3:0]     tick_ofs = 4'sh0;
  logic                  busy;
  logic                  strobe_q = 1'b0;
  int                    num_errors, samples_checked, cyc, t_chg, t_act, num_acts, base;
  logic [SCC_IDX_W-1:0]  idxs [6] = '{SCC_IDX_CTRL, SCC_IDX_IGN, SCC_IDX_SKEW, SCC_IDX_TSD,
                                      SCC_IDX_STAT, SCC_IDX_CNT};

  scc_top i_scc_top (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SAMPLE_CLK(SAMPLE_CLK), .STROBE_IN(STROBE_IN),
    .EXPECT_TICK(EXPECT_TICK), .SETUP_ERR(SETUP_ERR), .HOLD_ERR(HOLD_ERR),
    .STROBE_ACT(STROBE_ACT));
  scc_strobe_src i_scc_strobe_src (.core_clk(CORE_CLK), .rst_b(RST_B), .go(go), .lvl(lvl),
    .tick_en(tick_en), .tick_ofs(tick_ofs), .sample_clk(SAMPLE_CLK), .strobe(STROBE_IN),
    .tick(EXPECT_TICK), .busy(busy));

  always #2.5 CORE_CLK = ~CORE_CLK;

  // Strobe changes and action pulses are stamped with the core cycle they are seen in.
  always @(posedge CORE_CLK) begin
    cyc++;
    if (STROBE_IN !== strobe_q) t_chg = cyc;
    strobe_q = STROBE_IN;
    if (STROBE_ACT === 1'b1) begin
      num_acts++;
      t_act = cyc;
    end
  end

  // ********************************************************************
  // Shared tasks.
  // ********************************************************************
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [SCC_IDX_W-1:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= {idx, 2'b00};
    PWDATA  <= {24'h0, wd};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: bus transfer timed out", $time);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wreg(input logic [SCC_IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic reg_chk(input logic [SCC_IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 8'h00, rd, err);
    chk_val(rd, exp, "register read");
  endtask

  function automatic logic [7:0] ctrl(input logic pol, input logic edg, input logic [1:0] mode);
    ctrl = 8'h00;
    ctrl[SCC_POL_BIT] = pol;
    ctrl[SCC_EDGE_BIT] = edg;
    ctrl[SCC_MODE_LSB +: 2] = mode;
  endfunction

  // One strobe step to the given level; the tick lands ofs sample edges from the transition.
  task automatic frame(input logic l, input logic te, input int ofs);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    go       <= 1'b1;
    lvl      <= l;
    tick_en  <= te;
    tick_ofs <= 4'(ofs);
    @(posedge CORE_CLK);
    go <= 1'b0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (busy !== 1'b0) begin
      num_errors++;
      $display("CHECK FAILED at %0t: strobe source timed out", $time);
    end
    repeat (30) @(posedge CORE_CLK);
  endtask

  task automatic pulse(input logic te, input int ofs);
    frame(1'b1, te, ofs);
    frame(1'b0, 1'b0, 0);
  endtask

  task automatic errs(input logic [3:0] s, input logic [3:0] h);
    @(posedge CORE_CLK);
    SETUP_ERR <= s;
    HOLD_ERR  <= h;
    @(posedge CORE_CLK);
    SETUP_ERR <= 4'h0;
    HOLD_ERR  <= 4'h0;
  endtask

  // ********************************************************************
  // Scenarios.
  // ********************************************************************
  task automatic t_regs();
    logic [7:0]  masks [4] = '{SCC_CTRL_MASK, SCC_IGN_MASK, SCC_SKEW_MASK, SCC_TSD_MASK};
    logic [31:0] rd;
    logic        err;
    foreach (idxs[i]) reg_chk(idxs[i], 32'h0);
    apb(1'b0, 10'h124, 8'h00, rd, err);
    chk_val({31'h0, err}, 32'h1, "unmapped error");
    chk_val(rd, 32'h0, "unmapped data");
    for (int i = 0; i < 4; i++) begin
      wreg(idxs[i], 8'hFF);
      reg_chk(idxs[i], {24'h0, masks[i]});
      wreg(idxs[i], 8'h00);
    end
    wreg(SCC_IDX_CNT, 8'hFF);
    reg_chk(SCC_IDX_CNT, 32'h0);
  endtask

  task automatic t_modes();
    int a0;
    a0 = num_acts;
    pulse(1'b0, 0);
    chk_val(32'(num_acts - a0), 32'h0, "acts while disabled");
    wreg(SCC_IDX_CTRL, ctrl(1'b0, 1'b0, SCC_MODE_CONT));
    frame(1'b1, 1'b0, 0);
    base = t_act - t_chg;
    chk_val(32'(base > 12 && base < 20), 32'h1, "base latency");
    frame(1'b0, 1'b0, 0);
    pulse(1'b0, 0);
    pulse(1'b0, 0);
    chk_val(32'(num_acts - a0), 32'h3, "continuous acts");
    wreg(SCC_IDX_CTRL, 8'h00);
    reg_chk(SCC_IDX_CNT, 32'h3);
  endtask

  task automatic t_flags();
    errs(4'h5, 4'hA);
    reg_chk(SCC_IDX_STAT, 32'hA5);
    wreg(SCC_IDX_CTRL, 8'(1 << SCC_FLAG_RST_BIT));
    reg_chk(SCC_IDX_STAT, 32'h0);
    reg_chk(SCC_IDX_CNT, 32'h0);
    errs(4'hF, 4'hF);
    reg_chk(SCC_IDX_STAT, 32'h0);
    wreg(SCC_IDX_CTRL, 8'h00);
    errs(4'h3, 4'h0);
    reg_chk(SCC_IDX_STAT, 32'h03);
  endtask

  task automatic t_pol_edge();
    int a0;
    wreg(SCC_IDX_CTRL, ctrl(1'b1, 1'b0, SCC_MODE_OFF));
    wreg(SCC_IDX_CTRL, ctrl(1'b1, 1'b0, SCC_MODE_CONT));
    a0 = num_acts;
    frame(1'b1, 1'b0, 0);
    chk_val(32'(num_acts - a0), 32'h0, "rise with falling polarity");
    frame(1'b0, 1'b0, 0);
    chk_val(32'(num_acts - a0), 32'h1, "fall with falling polarity");
    chk_val(32'(t_act - t_chg), 32'(base), "falling polarity latency");
    wreg(SCC_IDX_CTRL, ctrl(1'b0, 1'b1, SCC_MODE_OFF));
    wreg(SCC_IDX_CTRL, ctrl(1'b0, 1'b1, SCC_MODE_CONT));
    frame(1'b1, 1'b0, 0);
    chk_val(32'(t_act - t_chg), 32'(base - 2), "falling clock edge latency");
    frame(1'b0, 1'b0, 0);
    wreg(SCC_IDX_CTRL, 8'h00);
  endtask

  task automatic t_single();
    int ign [3] = '{0, 2, 15};
    int a0;
    foreach (ign[k]) begin
      wreg(SCC_IDX_IGN, 8'(ign[k]));
      wreg(SCC_IDX_CTRL, ctrl(1'b0, 1'b0, SCC_MODE_NSHOT));
      a0 = num_acts;
      for (int p = 0; p < ign[k] + 2; p++) begin
        pulse(1'b0, 0);
        chk_val(32'(num_acts - a0), 32'(p >= ign[k]), "single shot acts");
      end
      wreg(SCC_IDX_CTRL, 8'h00);
    end
  endtask

  task automatic t_window();
    logic [7:0] skw [10] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h00, 8'h00, 8'h00,
                             8'h0F, 8'h0F};
    int         ofs [10] = '{-3, -2, 0, 1, 2, 0, -1, 1, -3, 3};
    logic       acc [10] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    int         a0;
    wreg(SCC_IDX_CTRL, ctrl(1'b0, 1'b0, SCC_MODE_CONT));
    foreach (skw[i]) begin
      wreg(SCC_IDX_SKEW, skw[i]);
      a0 = num_acts;
      pulse(1'b1, ofs[i]);
      chk_val(32'(num_acts - a0), {31'h0, acc[i]}, "skew window");
    end
    wreg(SCC_IDX_SKEW, 8'h00);
  endtask

  task automatic t_delay();
    int dl [2] = '{5, 127};
    int a0;
    int n;
    foreach (dl[i]) begin
      // Earlier captures still travel down the delay history; let them drain
      // so that a longer delay does not bring an old one to the output.
      repeat (4 * SCC_TSD_MAX + 8) @(posedge CORE_CLK);
      wreg(SCC_IDX_TSD, 8'(dl[i]));
      a0 = num_acts;
      n = 0;
      frame(1'b1, 1'b0, 0);
      while (num_acts == a0 && n < 800) begin
        @(posedge CORE_CLK);
        n++;
      end
      chk_val(32'(t_act - t_chg), 32'(base + 4 * dl[i]), "delayed action");
      frame(1'b0, 1'b0, 0);
    end
    wreg(SCC_IDX_CTRL, 8'h00);
  endtask

  // ********************************************************************
  // Sequence and watchdog.
  // ********************************************************************
  initial begin
    repeat (6) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_regs();
    t_modes();
    t_flags();
    t_pol_edge();
    t_single();
    t_window();
    t_delay();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge CORE_CLK);
    num_errors++;
    give_verdict();
  end
endmodule

// ===== verilog/scc_delay_line.sv
// Programmable timestamp delay counted in sample clock enables.
`timescale 1ns/1ps
module scc_delay_line #(
  parameter int DEPTH = 127,
  parameter int DLY_W = 7
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             en,
  input  wire logic             din,
  input  wire logic [DLY_W-1:0] dly,
  output logic                  dout_r
);

  logic [DEPTH-1:0] hist_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_r <= '0;
    end else if (en) begin
      hist_r <= {hist_r[DEPTH-2:0], din};
    end
  end

  // Stage k of the history holds the event from k+1 sample clocks back.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_r <= 1'b0;
    end else if (dly == '0) begin
      dout_r <= en & din;
    end else begin
      dout_r <= en & hist_r[dly - DLY_W'(1)];
    end
  end

endmodule

// ===== verilog/scc_edge_sampler.sv
// Sample clock edge selection and strobe transition detection.
`timescale 1ns/1ps
module scc_edge_sampler (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic sample_clk,
  input  wire logic strobe,
  input  wire logic edge_sel,
  input  wire logic pol_sel,
  output logic      samp_en,
  output logic      trans
);

  logic sclk_r;
  logic str_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_r <= 1'b0;
    end else begin
      sclk_r <= sample_clk;
    end
  end

  // The strobe is only looked at on the chosen sample clock edge.
  always_comb begin
    samp_en = edge_sel ? (sclk_r & ~sample_clk) : (~sclk_r & sample_clk);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      str_r <= 1'b0;
    end else if (samp_en) begin
      str_r <= strobe;
    end
  end

  always_comb begin
    trans = samp_en & (pol_sel ? (str_r & ~strobe) : (~str_r & strobe));
  end

  AST_EDGE_PICK: assert property (@(posedge core_clk) disable iff (!rst_b)
    samp_en |-> (sample_clk != $past(sample_clk)) && (sample_clk == !edge_sel))
    else $error("Strobe sampled on the wrong clock edge.");

  AST_POL_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
    trans |-> (strobe != pol_sel) && (str_r == pol_sel))
    else $error("Strobe transition of the wrong direction accepted.");

endmodule

// ===== verilog/scc_pkg.sv
// Shared constants for the strobe capture control block.
package scc_pkg;

  // ********************************************************************
  // Bus geometry.
  // ********************************************************************
  localparam int SCC_ADDR_W = 12;
  localparam int SCC_DATA_W = 32;
  localparam int SCC_IDX_W  = 10;
  localparam int SCC_REG_W  = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [SCC_IDX_W-1:0] SCC_IDX_CTRL = 10'h120;
  localparam logic [SCC_IDX_W-1:0] SCC_IDX_IGN  = 10'h121;
  localparam logic [SCC_IDX_W-1:0] SCC_IDX_SKEW = 10'h122;
  localparam logic [SCC_IDX_W-1:0] SCC_IDX_TSD  = 10'h123;
  localparam logic [SCC_IDX_W-1:0] SCC_IDX_STAT = 10'h128;
  localparam logic [SCC_IDX_W-1:0] SCC_IDX_CNT  = 10'h12A;

  // ********************************************************************
  // Field layout, masks and reset values.
  // ********************************************************************
  localparam int SCC_FLAG_RST_BIT = 6;
  localparam int SCC_POL_BIT      = 4;
  localparam int SCC_EDGE_BIT     = 3;
  localparam int SCC_MODE_LSB     = 1;
  localparam int SCC_NEG_LSB      = 2;
  localparam int SCC_POS_LSB      = 0;
  localparam int SCC_HOLD_LSB     = 4;
  localparam int SCC_ERR_W        = 4;
  localparam int SCC_IGN_W        = 4;
  localparam int SCC_WIN_W        = 2;
  localparam int SCC_TSD_W        = 7;

  localparam logic [SCC_REG_W-1:0] SCC_CTRL_MASK = 8'h5E;
  localparam logic [SCC_REG_W-1:0] SCC_IGN_MASK  = 8'h0F;
  localparam logic [SCC_REG_W-1:0] SCC_SKEW_MASK = 8'h0F;
  localparam logic [SCC_REG_W-1:0] SCC_TSD_MASK  = 8'h7F;
  localparam logic [SCC_REG_W-1:0] SCC_REG_RST   = 8'h00;

  // Capture mode codes.
  localparam logic [1:0] SCC_MODE_OFF   = 2'h0;
  localparam logic [1:0] SCC_MODE_CONT  = 2'h1;
  localparam logic [1:0] SCC_MODE_NSHOT = 2'h2;

  // Widest skew window and longest timestamp delay, in sample clocks.
  localparam int SCC_WIN_MAX = 3;
  localparam int SCC_TSD_MAX = 127;

endpackage

// ===== verilog/scc_top.sv
// Strobe capture control: APB registers, skew windows, modes and counter.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module scc_top (
  input  wire logic                           CORE_CLK,
  input  wire logic                           RST_B,
  input  wire logic                           PSEL,
  input  wire logic                           PENABLE,
  input  wire logic                           PWRITE,
  input  wire logic [scc_pkg::SCC_ADDR_W-1:0] PADDR,
  input  wire logic [scc_pkg::SCC_DATA_W-1:0] PWDATA,
  output logic      [scc_pkg::SCC_DATA_W-1:0] PRDATA,
  output logic                                PREADY,
  output logic                                PSLVERR,
  input  wire logic                           SAMPLE_CLK,
  input  wire logic                           STROBE_IN,
  input  wire logic                           EXPECT_TICK,
  input  wire logic [scc_pkg::SCC_ERR_W-1:0]  SETUP_ERR,
  input  wire logic [scc_pkg::SCC_ERR_W-1:0]  HOLD_ERR,
  output logic                                STROBE_ACT
);
  import scc_pkg::*;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_DONE
  } scc_shot_e;

  // ********************************************************************
  // Helper functions.
  // ********************************************************************
  function automatic logic hits(input logic [SCC_ADDR_W-1:0] addr,
                                input logic [SCC_IDX_W-1:0]  idx);
    return (addr == {idx, 2'b00});
  endfunction

  // An expected tick within the window around the delayed transition.
  function automatic logic in_win(input logic [2*SCC_WIN_MAX:0] ex,
                                  input logic [SCC_WIN_W-1:0]   neg,
                                  input logic [SCC_WIN_W-1:0]   pos);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j <= SCC_WIN_MAX; j++) begin
      if (j <= int'(neg) && ex[SCC_WIN_MAX-j]) begin
        hit = 1'b1;
      end
      if (j <= int'(pos) && ex[SCC_WIN_MAX+j]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ********************************************************************
  // Registers and bus slave.
  // ********************************************************************
  logic [SCC_REG_W-1:0]   ctrl_r;
  logic [SCC_REG_W-1:0]   ign_r;
  logic [SCC_REG_W-1:0]   skew_r;
  logic [SCC_REG_W-1:0]   tsd_r;
  logic [SCC_ERR_W-1:0]   setup_flg_r;
  logic [SCC_ERR_W-1:0]   hold_flg_r;
  logic [SCC_REG_W-1:0]   cnt_r;
  logic                   wr_acc;
  logic                   setup_ph;
  logic                   mapped;
  logic [SCC_REG_W-1:0]   rd_val;
  logic                   flag_rst;
  logic                   pol_sel;
  logic                   edge_sel;
  logic [1:0]             mode;
  logic [SCC_WIN_W-1:0]   win_neg;
  logic [SCC_WIN_W-1:0]   win_pos;
  logic [SCC_TSD_W-1:0]   tsd;
  logic                   rearm;

  assign wr_acc   = PSEL & PENABLE & PWRITE;
  assign setup_ph = PSEL & ~PENABLE;

  always_comb begin
    mapped = hits(PADDR, SCC_IDX_CTRL) | hits(PADDR, SCC_IDX_IGN) |
             hits(PADDR, SCC_IDX_SKEW) | hits(PADDR, SCC_IDX_TSD) |
             hits(PADDR, SCC_IDX_STAT) | hits(PADDR, SCC_IDX_CNT);
  end

  // The slave never stretches a transfer; errors flag unmapped words.
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  always_comb begin
    rd_val = '0;
    if (hits(PADDR, SCC_IDX_CTRL)) begin
      rd_val = ctrl_r;
    end else if (hits(PADDR, SCC_IDX_IGN)) begin
      rd_val = ign_r;
    end else if (hits(PADDR, SCC_IDX_SKEW)) begin
      rd_val = skew_r;
    end else if (hits(PADDR, SCC_IDX_TSD)) begin
      rd_val = tsd_r;
    end else if (hits(PADDR, SCC_IDX_STAT)) begin
      rd_val = {hold_flg_r, setup_flg_r};
    end else if (hits(PADDR, SCC_IDX_CNT)) begin
      rd_val = cnt_r;
    end
  end

  // Read data is caught in the setup phase, so it stands through access.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= '0;
    end else if (setup_ph) begin
      PRDATA <= {{(SCC_DATA_W-SCC_REG_W){1'b0}}, rd_val};
    end
  end

  // Reserved bits are masked off on write and therefore read as zero.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_r <= SCC_REG_RST;
      ign_r  <= SCC_REG_RST;
      skew_r <= SCC_REG_RST;
      tsd_r  <= SCC_REG_RST;
    end else if (wr_acc) begin
      if (hits(PADDR, SCC_IDX_CTRL)) begin
        ctrl_r <= PWDATA[SCC_REG_W-1:0] & SCC_CTRL_MASK;
      end
      if (hits(PADDR, SCC_IDX_IGN)) begin
        ign_r <= PWDATA[SCC_REG_W-1:0] & SCC_IGN_MASK;
      end
      if (hits(PADDR, SCC_IDX_SKEW)) begin
        skew_r <= PWDATA[SCC_REG_W-1:0] & SCC_SKEW_MASK;
      end
      if (hits(PADDR, SCC_IDX_TSD)) begin
        tsd_r <= PWDATA[SCC_REG_W-1:0] & SCC_TSD_MASK;
      end
    end
  end

  assign flag_rst = ctrl_r[SCC_FLAG_RST_BIT];
  assign pol_sel  = ctrl_r[SCC_POL_BIT];
  assign edge_sel = ctrl_r[SCC_EDGE_BIT];
  assign mode     = ctrl_r[SCC_MODE_LSB +: 2];
  assign win_neg  = skew_r[SCC_NEG_LSB +: SCC_WIN_W];
  assign win_pos  = skew_r[SCC_POS_LSB +: SCC_WIN_W];
  assign tsd      = tsd_r[SCC_TSD_W-1:0];

  // Any write that selects single mode starts a fresh shot.
  assign rearm = wr_acc & hits(PADDR, SCC_IDX_CTRL) &
                 (PWDATA[SCC_MODE_LSB +: 2] == SCC_MODE_NSHOT);

  // ********************************************************************
  // Strobe detection and skew windows.
  // ********************************************************************
  logic                   samp_en;
  logic                   trans;
  logic [SCC_WIN_MAX:0]   tr_pipe_r;
  logic [2*SCC_WIN_MAX:0] exp_pipe_r;
  logic                   accepted;

  scc_edge_sampler u_sampler (
    .core_clk   (CORE_CLK),
    .rst_b      (RST_B),
    .sample_clk (SAMPLE_CLK),
    .strobe     (STROBE_IN),
    .edge_sel   (edge_sel),
    .pol_sel    (pol_sel),
    .samp_en    (samp_en),
    .trans      (trans)
  );

  // Transitions are judged four sample edges late, once the expected
  // ticks up to three edges on either side of them are known.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tr_pipe_r  <= '0;
      exp_pipe_r <= '0;
    end else if (samp_en) begin
      tr_pipe_r  <= {tr_pipe_r[SCC_WIN_MAX-1:0], trans};
      exp_pipe_r <= {exp_pipe_r[2*SCC_WIN_MAX-1:0], EXPECT_TICK};
    end
  end

  always_comb begin
    accepted = samp_en & tr_pipe_r[SCC_WIN_MAX] &
               ~in_win(exp_pipe_r, win_neg, win_pos);
  end

  // ********************************************************************
  // Capture modes.
  // ********************************************************************
  scc_shot_e            shot_r;
  logic [SCC_IGN_W-1:0] skip_r;
  logic                 act;

  always_comb begin
    unique case (mode)
      SCC_MODE_CONT: begin
        act = accepted;
      end
      SCC_MODE_NSHOT: begin
        act = accepted & (shot_r == ST_ARM) & (skip_r == '0);
      end
      default: begin
        act = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      shot_r <= ST_IDLE;
      skip_r <= '0;
    end else if (rearm) begin
      shot_r <= ST_ARM;
      skip_r <= ign_r[SCC_IGN_W-1:0];
    end else if (mode != SCC_MODE_NSHOT) begin
      shot_r <= ST_IDLE;
    end else if (shot_r == ST_ARM && accepted) begin
      if (skip_r == '0) begin
        shot_r <= ST_DONE;
      end else begin
        skip_r <= skip_r - SCC_IGN_W'(1);
      end
    end
  end

  // ********************************************************************
  // Status flags and capture counter.
  // ********************************************************************
  // Holding the flag reset overrides new errors and captures alike.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      setup_flg_r <= '0;
      hold_flg_r  <= '0;
    end else if (flag_rst) begin
      setup_flg_r <= '0;
      hold_flg_r  <= '0;
    end else begin
      setup_flg_r <= setup_flg_r | SETUP_ERR;
      hold_flg_r  <= hold_flg_r | HOLD_ERR;
    end
  end

  // Software should read the count only with capture disabled.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_r <= '0;
    end else if (flag_rst) begin
      cnt_r <= '0;
    end else if (act) begin
      cnt_r <= cnt_r + SCC_REG_W'(1);
    end
  end

  // ********************************************************************
  // Timestamp delay.
  // ********************************************************************
  scc_delay_line #(
    .DEPTH (SCC_TSD_MAX),
    .DLY_W (SCC_TSD_W)
  ) u_delay (
    .core_clk (CORE_CLK),
    .rst_b    (RST_B),
    .en       (samp_en),
    .din      (act),
    .dly      (tsd),
    .dout_r   (STROBE_ACT)
  );

  // ********************************************************************
  // Assertions and cover points.
  // ********************************************************************
  AST_FLAG_HOLD: assert property (
    flag_rst |=> (setup_flg_r == '0) && (hold_flg_r == '0) && (cnt_r == '0))
    else $error("Flags not held clear during flag reset.");

  AST_MODE_OFF: assert property (
    (mode == SCC_MODE_OFF) |-> !act)
    else $error("Capture acted while disabled.");

  AST_CONT_ALL: assert property (
    (mode == SCC_MODE_CONT) && accepted |-> act)
    else $error("Continuous mode missed a valid strobe.");

  AST_NSHOT_SKIP: assert property (
    (mode == SCC_MODE_NSHOT) && (shot_r == ST_ARM) && accepted && (skip_r != '0)
      && !rearm |-> !act ##1 (skip_r == $past(skip_r) - SCC_IGN_W'(1)))
    else $error("Single mode did not skip an ignored transition.");

  AST_DONE_STOP: assert property (
    (shot_r == ST_DONE) |-> !act)
    else $error("Single mode acted again without rearm.");

  AST_WIN_NEG: assert property (
    samp_en && tr_pipe_r[SCC_WIN_MAX] && (win_neg == 2'h3) && exp_pipe_r[0]
      |-> !accepted)
    else $error("Strobe inside negative window was accepted.");

  AST_WIN_POS: assert property (
    samp_en && tr_pipe_r[SCC_WIN_MAX] && (win_pos == 2'h3) &&
      exp_pipe_r[2*SCC_WIN_MAX] |-> !accepted)
    else $error("Strobe inside positive window was accepted.");

  AST_NO_SKEW: assert property (
    samp_en && tr_pipe_r[SCC_WIN_MAX] && (skew_r == '0) &&
      !exp_pipe_r[SCC_WIN_MAX] |-> accepted)
    else $error("Zero window rejected a misaligned strobe.");

  AST_DELAY_ZERO: assert property (
    act && (tsd == '0) |=> STROBE_ACT)
    else $error("Undelayed timestamp did not appear next cycle.");

  AST_CNT_STEP: assert property (
    act && !flag_rst |=> (cnt_r == $past(cnt_r) + SCC_REG_W'(1)))
    else $error("Capture counter did not advance on capture.");

  COV_CONT: cover property ((mode == SCC_MODE_CONT) && act);
  COV_NSHOT: cover property ((shot_r == ST_ARM) && (skip_r != '0) ##[1:200] act);
  COV_DELAYED: cover property ((tsd != '0) && STROBE_ACT);
  COV_WIN_DROP: cover property (samp_en && tr_pipe_r[SCC_WIN_MAX] && !accepted);

endmodule
